// ---- hw/bcl_pkg.sv ----
// Package of offsets, field positions and reset values for the bridge control low byte.
`default_nettype none
package bcl_pkg;
  localparam logic [7:0] OFS_INT_PIN   = 8'h3d;
  localparam logic [7:0] OFS_BCTL_LOW  = 8'h3e;
  localparam logic [7:0] OFS_BCTL_HIGH = 8'h3f;
  localparam int BIT_PARITY  = 0;
  localparam int BIT_SERR    = 1;
  localparam int BIT_ISA     = 2;
  localparam int BIT_VGA     = 3;
  localparam int BIT_RSVD    = 4;
  localparam int BIT_MABORT  = 5;
  localparam int BIT_SECRST  = 6;
  localparam int BIT_FASTB2B = 7;
  localparam logic [7:0] RST_BCTL_LOW = 8'h00;
  localparam logic [7:0] INT_PIN_VAL  = 8'h00;
  localparam logic [7:0] BCTL_WMASK   = 8'h6f;
  localparam logic [31:0] ISA_SPACE_TOP = 32'h0000_ffff;
  localparam logic [9:0]  ISA_ALIAS_LOW = 10'h100;
  localparam logic [31:0] MABORT_READ_DATA = 32'hffff_ffff;
endpackage
`default_nettype wire

// ---- hw/bcl_if.sv ----
// Interface carrying the control bits from the register bank to the forwarding decode.
`default_nettype none
interface bcl_ctl_if;
  logic [7:0] ctl;
  logic       isa_lock;
  modport regs (output ctl, output isa_lock);
  modport dec  (input ctl, input isa_lock);
endinterface
`default_nettype wire

// ---- hw/bcl_decode.sv ----
// Forwarding decode steered by the bridge control low byte.
`default_nettype none
module bcl_decode
(
  input  wire logic        clock,
  input  wire logic        srst,
  bcl_ctl_if.dec           ctl_if,
  input  wire logic [31:0] io_addr,
  input  wire logic [31:0] io_base,
  input  wire logic [31:0] io_limit,
  input  wire logic        vga_hit,
  output var  logic        fwd_down,
  output var  logic        fwd_up
);
  typedef struct packed
  {
    logic down;
    logic up;
  } bcl_dec_state_t;

  bcl_dec_state_t st;
  bcl_dec_state_t next_st;
  logic           in_window;
  logic           isa_alias;
  logic           isa_on;

  always_comb
  begin
    in_window = (io_addr >= io_base) && (io_addr <= io_limit);
    isa_alias = (io_addr <= bcl_pkg::ISA_SPACE_TOP)
      && (io_addr[9:0] >= bcl_pkg::ISA_ALIAS_LOW);
    // A write-protected ISA bit disables the blocking feature outright.
    isa_on = ctl_if.ctl[bcl_pkg::BIT_ISA] && !ctl_if.isa_lock;
    next_st.down = (in_window && !(isa_on && isa_alias))
      || (ctl_if.ctl[bcl_pkg::BIT_VGA] && vga_hit);
    next_st.up = !in_window || (isa_on && isa_alias);
    if (srst)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    st <= next_st;
  end

  assign fwd_down = st.down;
  assign fwd_up   = st.up;

  vga_fwd_a: assert property (@(posedge clock) disable iff (srst)
    ctl_if.ctl[bcl_pkg::BIT_VGA] && vga_hit |=> fwd_down)
    else $error("VGA address not forwarded downstream.");
  isa_block_a: assert property (@(posedge clock) disable iff (srst)
    isa_on && isa_alias && !vga_hit |=> !fwd_down && fwd_up)
    else $error("ISA alias not blocked.");
endmodule
`default_nettype wire

// ---- hw/bcl_top.sv ----
// Bridge control low byte register bank with master abort and error forwarding.
// What this block does
// - Interrupt pin register reads zero; writes do nothing.
// - Bit 0 clear ignores secondary parity errors; set enables detection and reporting.
// - Bit 1 gates secondary system error forwarding to the primary side.
// - ISA bit clear forwards every I/O address inside the base/limit window.
// - ISA bit set blocks window addresses below 64K in last 768 bytes of 1K.
// - EEPROM write protect with EEPROM init makes ISA bit read-only and unusable.
// - VGA bit set forwards VGA memory and I/O downstream regardless of others.
// - Bit 4 reserved: reads zero, ignores writes.
// - Master abort mode clear: reads return all ones, writes discarded.
// - Master abort mode set: master abort reported as target abort.
// - Locked cycles always finish a master abort as a target abort.
// - Bit 6 set holds the secondary reset output asserted.
// - No fast back-to-back cycles; bit 7 reads zero, value one reserved.
// - The bridge control register sits at configuration offset 3Eh.
//
// Design decision made here: the strobed register port.
`default_nettype none
module bcl_top
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        eeprom_isa_wp,
  input  wire logic        eeprom_init_en,
  input  wire logic        secondary_system_error_n,
  output logic             primary_serr,
  input  wire logic        sec_parity_error,
  output logic             parity_report,
  input  wire logic        sec_master_abort,
  input  wire logic        abort_is_read,
  input  wire logic        abort_locked,
  output logic             target_abort,
  output logic             read_all_ones,
  output logic             write_discard,
  output logic      [31:0] abort_rdata,
  output logic             secondary_reset_out_n,
  output logic             fast_b2b_enable,
  input  wire logic [31:0] io_addr,
  input  wire logic [31:0] io_base,
  input  wire logic [31:0] io_limit,
  input  wire logic        vga_hit,
  output logic             fwd_down,
  output logic             fwd_up
);
  typedef struct packed
  {
    logic [7:0]  ctl;
    logic [7:0]  rdata;
    logic [2:0]  serr_sync;
    logic        serr_seen;
    logic        isa_lock;
    logic        parity;
    logic        tabort;
    logic        ones;
    logic        discard;
    logic [31:0] ardata;
  } bcl_state_t;

  bcl_state_t st;
  bcl_state_t next_st;
  bcl_ctl_if  ctl_if ();

  function automatic logic [7:0] bcl_read(input logic [7:0] addr, input logic [7:0] ctl);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      bcl_pkg::OFS_INT_PIN:  v = bcl_pkg::INT_PIN_VAL;
      bcl_pkg::OFS_BCTL_LOW: v = ctl;
      default:               v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb
  begin
    logic [7:0] wmask;
    logic       mabort_report;
    wmask = bcl_pkg::BCTL_WMASK;
    next_st = st;
    // Strap captured each clock so the lock follows the loader state after reset.
    next_st.isa_lock = eeprom_isa_wp && eeprom_init_en;
    if (st.isa_lock)
    begin
      wmask[bcl_pkg::BIT_ISA] = 1'b0;
      next_st.ctl[bcl_pkg::BIT_ISA] = 1'b0;
    end
    if (reg_write && reg_addr == bcl_pkg::OFS_BCTL_LOW)
    begin
      next_st.ctl = (reg_wdata & wmask) | (st.ctl & ~wmask & ~bcl_pkg::BCTL_WMASK);
    end
    // Writes to the interrupt pin offset fall through with no effect.
    next_st.rdata = reg_read ? bcl_read(reg_addr, st.ctl) : 8'h00;
    next_st.serr_sync = {st.serr_sync[1:0], ~secondary_system_error_n};
    if (st.serr_sync[2] == st.serr_sync[1])
    begin
      next_st.serr_seen = st.serr_sync[2];
    end
    next_st.parity = sec_parity_error && st.ctl[bcl_pkg::BIT_PARITY];
    mabort_report = st.ctl[bcl_pkg::BIT_MABORT] || abort_locked;
    next_st.tabort = sec_master_abort && mabort_report;
    next_st.ones = sec_master_abort && !mabort_report && abort_is_read;
    next_st.discard = sec_master_abort && !mabort_report && !abort_is_read;
    next_st.ardata = (sec_master_abort && !mabort_report && abort_is_read)
      ? bcl_pkg::MABORT_READ_DATA : 32'h0000_0000;
    if (srst)
    begin
      next_st = '0;
      next_st.ctl = bcl_pkg::RST_BCTL_LOW;
    end
  end

  always_ff @(posedge clock)
  begin
    st <= next_st;
  end

  assign ctl_if.ctl      = st.ctl;
  assign ctl_if.isa_lock = st.isa_lock;

  bcl_decode u_decode
  (
    .clock    (clock),
    .srst     (srst),
    .ctl_if   (ctl_if),
    .io_addr  (io_addr),
    .io_base  (io_base),
    .io_limit (io_limit),
    .vga_hit  (vga_hit),
    .fwd_down (fwd_down),
    .fwd_up   (fwd_up)
  );

  assign reg_rdata     = st.rdata;
  assign primary_serr  = st.serr_seen && st.ctl[bcl_pkg::BIT_SERR];
  assign parity_report = st.parity;
  assign target_abort  = st.tabort;
  assign read_all_ones = st.ones;
  assign write_discard = st.discard;
  assign abort_rdata   = st.ardata;
  // Bridge reset also holds the secondary bus in reset.
  assign secondary_reset_out_n = !(st.ctl[bcl_pkg::BIT_SECRST] || srst);
  assign fast_b2b_enable = 1'b0;

  int_pin_zero_a: assert property (@(posedge clock) disable iff (srst)
    reg_read && reg_addr == bcl_pkg::OFS_INT_PIN |=> reg_rdata == 8'h00)
    else $error("Interrupt pin read not zero.");
  rsvd_bits_a: assert property (@(posedge clock) disable iff (srst)
    st.ctl[4] == 1'b0 && st.ctl[7] == 1'b0)
    else $error("Reserved control bit set.");
  ctl_write_a: assert property (@(posedge clock) disable iff (srst)
    reg_write && reg_addr == bcl_pkg::OFS_BCTL_LOW && !st.isa_lock
    |=> st.ctl == ($past(reg_wdata) & 8'h6f))
    else $error("Control write not stored.");
  ctl_hold_a: assert property (@(posedge clock) disable iff (srst)
    !(reg_write && reg_addr == bcl_pkg::OFS_BCTL_LOW) && !st.isa_lock
    |=> $stable(st.ctl))
    else $error("Control changed without write.");
  parity_gate_a: assert property (@(posedge clock) disable iff (srst)
    !st.ctl[0] |=> !parity_report)
    else $error("Parity reported while disabled.");
  serr_gate_a: assert property (@(posedge clock) disable iff (srst)
    !st.ctl[1] |-> !primary_serr)
    else $error("System error forwarded while disabled.");
  isa_lock_a: assert property (@(posedge clock) disable iff (srst)
    st.isa_lock |=> !st.ctl[2])
    else $error("ISA bit set while write protected.");
  abort_hide_a: assert property (@(posedge clock) disable iff (srst)
    sec_master_abort && !st.ctl[5] && !abort_locked && abort_is_read
    |=> read_all_ones && !target_abort && abort_rdata == 32'hffff_ffff)
    else $error("Master abort not hidden.");
  abort_report_a: assert property (@(posedge clock) disable iff (srst)
    sec_master_abort && (st.ctl[5] || abort_locked) |=> target_abort && !write_discard)
    else $error("Master abort not reported as target abort.");
  sec_reset_a: assert property (@(posedge clock) disable iff (srst)
    st.ctl[6] |-> !secondary_reset_out_n)
    else $error("Secondary reset not asserted.");
endmodule
`default_nettype wire

// ---- testbench/bridge_control_low_byte_test.sv ----
// Self-checking bench for the bridge control low byte register bank.
`default_nettype none
module bridge_control_low_byte_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = bcl_pkg::OFS_BCTL_LOW;
  localparam logic [7:0] PIN = bcl_pkg::OFS_INT_PIN;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0, reg_read = 1'b0, eeprom_isa_wp = 1'b0, eeprom_init_en = 1'b0;
  logic        secondary_system_error_n = 1'b1, sec_parity_error = 1'b0, vga_hit = 1'b0;
  logic        sec_master_abort = 1'b0, abort_is_read = 1'b0, abort_locked = 1'b0;
  logic [31:0] io_addr = 32'h0, io_base = 32'h0, io_limit = 32'h0000_ffff;
  logic [7:0]  reg_rdata;
  logic [31:0] abort_rdata;
  logic        primary_serr, parity_report, target_abort, read_all_ones, write_discard;
  logic        secondary_reset_out_n, fast_b2b_enable, fwd_down, fwd_up;
  int          err_count = 0, num_checks = 0, cycles = 0;

  bcl_top dut (.clock, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .eeprom_isa_wp, .eeprom_init_en, .secondary_system_error_n, .primary_serr,
    .sec_parity_error, .parity_report, .sec_master_abort, .abort_is_read, .abort_locked,
    .target_abort, .read_all_ones, .write_discard, .abort_rdata, .secondary_reset_out_n,
    .fast_b2b_enable, .io_addr, .io_base, .io_limit, .vga_hit, .fwd_down, .fwd_up);

  always #10 clock = ~clock;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A hang would otherwise stall the run; the whole sequence needs under a hundred cycles.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic dec(input logic [31:0] a, input logic v);
    @(posedge clock);
    io_addr <= a;
    vga_hit <= v;
    @(posedge clock);
    #1;
  endtask

  task automatic t_regs;
    rd(PIN, 8'h00);
    chk(secondary_reset_out_n, 1'b1);
    rd(CTL, 8'h00);
    wr(CTL, 8'hff);
    rd(CTL, 8'h6f);
    chk(secondary_reset_out_n, 1'b0);
    chk(fast_b2b_enable, 1'b0);
    wr(PIN, 8'hff);
    rd(PIN, 8'h00);
    wr(bcl_pkg::OFS_BCTL_HIGH, 8'h00);
    rd(CTL, 8'h6f);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    rd(CTL, 8'h00);
    chk(secondary_reset_out_n, 1'b1);
    $display("register test done");
  endtask

  task automatic t_events(input logic [7:0] c);
    wr(CTL, c);
    @(posedge clock);
    sec_parity_error <= 1'b1;
    sec_master_abort <= 1'b1;
    abort_is_read    <= 1'b1;
    @(posedge clock);
    sec_parity_error <= 1'b0;
    abort_is_read    <= 1'b0;
    #1;
    chk(parity_report, c[0]);
    chk(target_abort, c[5]);
    chk(read_all_ones, !c[5]);
    chk(abort_rdata, c[5] ? 32'h0 : 32'hffff_ffff);
    @(posedge clock);
    abort_locked <= 1'b1;
    #1;
    chk(write_discard, !c[5]);
    @(posedge clock);
    sec_master_abort <= 1'b0;
    abort_locked     <= 1'b0;
    #1;
    chk(target_abort, 1'b1);
    @(posedge clock);
    secondary_system_error_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk(primary_serr, c[1]);
    @(posedge clock);
    secondary_system_error_n <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    chk(primary_serr, 1'b0);
    $display("event test done");
  endtask

  task automatic t_decode;
    dec(32'h0000_0100, 1'b0);
    chk(fwd_down, 1'b1);
    wr(CTL, 8'h04);
    dec(32'h0000_0100, 1'b0);
    chk(fwd_down, 1'b0);
    chk(fwd_up, 1'b1);
    dec(32'h0000_03ff, 1'b0);
    chk(fwd_down, 1'b0);
    dec(32'h0000_0400, 1'b0);
    chk(fwd_down, 1'b1);
    wr(CTL, 8'h08);
    dec(32'h0002_0000, 1'b1);
    chk(fwd_down, 1'b1);
    wr(CTL, 8'h00);
    dec(32'h0002_0000, 1'b1);
    chk(fwd_down, 1'b0);
    @(posedge clock);
    eeprom_isa_wp  <= 1'b1;
    eeprom_init_en <= 1'b1;
    wr(CTL, 8'h04);
    rd(CTL, 8'h00);
    dec(32'h0000_0100, 1'b0);
    chk(fwd_down, 1'b1);
    $display("decode test done");
  endtask

  initial
  begin
    repeat (7) @(posedge clock);
    #1;
    chk(secondary_reset_out_n, 1'b0);
    @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_events(8'h00);
    t_events(8'h23);
    t_decode();
    end_sim();
  end
endmodule
`default_nettype wire
